// [core/dual_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_timer
    import timer_pkg::*;
#(
    parameter int ADDR_W = 8 // decoded address width
) (
    input wire logic CLK, // system clock, 100 MHz
    input wire logic RST_N, // async reset, active low
    input wire logic HSEL, // slave select
    input wire logic [ADDR_W-1:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write when high
    input wire logic [2:0] HSIZE, // word only
    input wire logic [31:0] HWDATA, // write data
    input wire logic HREADY, // bus ready
    output logic [31:0] HRDATA, // read data
    output logic HREADYOUT, // always ready
    output logic HRESP, // always okay
    input wire logic TIMER0_COUNT_PIN, // timer0 external count
    input wire logic TIMER1_COUNT_PIN, // timer1 external count
    input wire logic GATE_INPUT0, // timer0 gate
    input wire logic GATE_INPUT1, // timer1 gate
    input wire logic EXT_CLK, // external clock for the /8 source
    output logic TIMER0_IRQ, // timer0 interrupt request
    output logic TIMER1_IRQ, // timer1 interrupt request
    output logic TIMER1_OVF_PULSE // timer1 overflow for other users
);
    logic [7:0] ctrl_reg; // timer_control_reg
    logic [7:0] mode_reg; // timer_mode_reg
    logic [7:0] clkc_reg; // clock_control_reg
    logic [7:0] extc_reg; // ext_input_config_reg
    logic [7:0] ien_reg; // interrupt_enable_reg
    logic [7:0] lo_reg [2]; // timer low bytes
    logic [7:0] hi_reg [2]; // timer high bytes
    logic [7:0] lo_next [2]; // low bytes after counting
    logic [7:0] hi_next [2]; // high bytes after counting
    logic [1:0] ovf_main; // overflow of each main counter
    logic ovf_hi0; // overflow of timer0 high byte in split
    logic ovf1_reg; // registered timer1 overflow pulse
    logic [31:0] rdata_reg; // read data register
    logic wr_pend_reg; // write data phase pending
    logic [ADDR_W-1:0] wr_addr_reg; // address of pending write
    logic [3:0] div12_reg; // sysclk prescaler count
    logic [2:0] ext8_reg; // external clock edge count
    logic presc_tick; // selected prescaler tick
    logic ext8_tick; // ext clock / 8 tick
    logic [LANES-1:0] raw_pins; // pins to synchronise
    logic [LANES-1:0] lvl; // synchronised levels
    logic [LANES-1:0] fall; // falling edge pulses
    logic [LANES-1:0] rise; // rising edge pulses
    logic split; // timer0 in split mode
    logic addr_ok; // valid address phase
    logic wr_en; // write data phase this cycle

    assign HREADYOUT = 1'b1; // zero wait states
    assign HRESP = 1'b0; // okay only
    assign HRDATA = rdata_reg;
    assign split = (mode_reg[1:0] == MODE_SPLIT);
    assign addr_ok = HSEL & HTRANS[1] & HREADY;
    assign wr_en = wr_pend_reg;

    // input conditioning, one synchroniser per external pin
    assign raw_pins = {EXT_CLK, GATE_INPUT1, GATE_INPUT0,
                       TIMER1_COUNT_PIN, TIMER0_COUNT_PIN};
    for (genvar p = 0; p < LANES; p++) begin : g_sync
        pin_sync u_sync (
            .CLK(CLK),
            .RST_N(RST_N),
            .PIN(raw_pins[p]),
            .LEVEL(lvl[p]),
            .FALL(fall[p]),
            .RISE(rise[p])
        );
    end

    // bus address phase: capture writes, sample read data now
    // a read right behind a write to the same register sees the old value
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_ok & HWRITE;
            wr_addr_reg <= HADDR;
        end
    end

    // read mux, registered so data stand through the data phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= '0;
        end else if (addr_ok && !HWRITE) begin
            case (HADDR)
                CTRL_ADDR: rdata_reg <= {24'h0, ctrl_reg[7:4], 4'h0};
                MODE_ADDR: rdata_reg <= {24'h0, mode_reg};
                CLKC_ADDR: rdata_reg <= {24'h0, clkc_reg};
                T0LO_ADDR: rdata_reg <= {24'h0, lo_reg[0]};
                T1LO_ADDR: rdata_reg <= {24'h0, lo_reg[1]};
                T0HI_ADDR: rdata_reg <= {24'h0, hi_reg[0]};
                T1HI_ADDR: rdata_reg <= {24'h0, hi_reg[1]};
                EXTC_ADDR: rdata_reg <= {24'h0, extc_reg};
                IEN_ADDR: rdata_reg <= {24'h0, ien_reg};
                default: rdata_reg <= '0; // unmapped reads zero
            endcase
        end
    end

    // plain configuration registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_reg <= BYTE_RST;
            clkc_reg <= BYTE_RST;
            extc_reg <= BYTE_RST;
            ien_reg <= BYTE_RST;
        end else if (wr_en) begin
            if (wr_addr_reg == MODE_ADDR) begin
                mode_reg <= HWDATA[7:0];
            end
            if (wr_addr_reg == CLKC_ADDR) begin
                clkc_reg <= HWDATA[7:0];
            end
            if (wr_addr_reg == EXTC_ADDR) begin
                extc_reg <= HWDATA[7:0];
            end
            if (wr_addr_reg == IEN_ADDR) begin
                ien_reg <= HWDATA[7:0];
            end
        end
    end

    // control: run bits by software, flags set by hardware win over writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= BYTE_RST;
        end else begin
            if (wr_en && wr_addr_reg == CTRL_ADDR) begin
                ctrl_reg <= {HWDATA[7:4], 4'h0};
            end
            if (ovf_main[0]) begin
                ctrl_reg[TF0_BIT] <= 1'b1;
            end
            if (split ? ovf_hi0 : ovf_main[1]) begin
                ctrl_reg[TF1_BIT] <= 1'b1;
            end
        end
    end

    // sysclk prescaler: 0..11; /4 taps every fourth count of it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div12_reg <= '0;
        end else if (div12_reg == DIV12_LAST) begin
            div12_reg <= '0;
        end else begin
            div12_reg <= div12_reg + 4'h1;
        end
    end

    // external clock is sampled, so it must run below a quarter sysclk
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext8_reg <= '0;
        end else if (rise[LANE_EXTC]) begin
            ext8_reg <= ext8_reg + 3'h1;
        end
    end
    assign ext8_tick = rise[LANE_EXTC] && (ext8_reg == DIV8_LAST);

    // prescaler source choice
    always_comb begin
        case (clkc_reg[SCA_LSB +: 2])
            SCA_DIV12: presc_tick = (div12_reg == DIV12_LAST);
            SCA_EXT8: presc_tick = ext8_tick;
            default: presc_tick = (div12_reg[1:0] == DIV4_LAST);
        endcase
    end

    // per-timer counting datapath
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        logic [1:0] mode; // this timer's mode field
        logic gate_en; // gate enable bit
        logic csel; // count select: external pin
        logic int_tick; // internal timebase tick
        logic gate_ok; // gate input at active level
        logic run; // run control
        logic go; // increment this cycle
        logic go_hi; // split high byte increment
        logic [12:0] c13; // 13-bit count
        logic [15:0] c16; // 16-bit count

        assign mode = mode_reg[MODE_NIB*i +: 2];
        assign gate_en = mode_reg[MODE_NIB*i + GATE_OFS];
        // timer1 loses its external source while timer0 is split
        assign csel = mode_reg[MODE_NIB*i + CSEL_OFS] & ~(i == 1 && split);
        assign int_tick = clkc_reg[SYS0_BIT - i] | presc_tick;
        // gate active level equals its polarity bit
        assign gate_ok = (i == 0)
            ? (lvl[LANE_TIMER0_GATE_ENABLE] == extc_reg[POL0_BIT])
            : (lvl[LANE_GATE1] == extc_reg[POL1_BIT]);
        // timer1 run comes from its mode field while timer0 is split
        assign run = (i == 1 && split) ? 1'b1
                   : ctrl_reg[i == 0 ? TR0_BIT : TR1_BIT];
        assign go = run && (!gate_en || gate_ok)
                 && (csel ? fall[LANE_CNT0 + i] : int_tick)
                 && !(i == 1 && mode == MODE_SPLIT);
        assign go_hi = (i == 0) && split && ctrl_reg[TR1_BIT]
                    && int_tick;
        assign c13 = {hi_reg[i], lo_reg[i][4:0]} + 13'h1;
        assign c16 = {hi_reg[i], lo_reg[i]} + 16'h1;

        // next count and overflow per mode; split counting is done for timer0 only
        always_comb begin
            lo_next[i] = lo_reg[i];
            hi_next[i] = hi_reg[i];
            ovf_main[i] = 1'b0;
            case (mode)
                MODE_13BIT: begin
                    if (go) begin
                        // bits 7:5 of the low byte are left as they are
                        lo_next[i] = {lo_reg[i][7:5], c13[4:0]};
                        hi_next[i] = c13[12:5];
                        ovf_main[i] = (c13 == 13'h0);
                    end
                end
                MODE_16BIT: begin
                    if (go) begin
                        {hi_next[i], lo_next[i]} = c16;
                        ovf_main[i] = (c16 == 16'h0);
                    end
                end
                MODE_RELOAD: begin
                    if (go) begin
                        ovf_main[i] = (lo_reg[i] == 8'hff);
                        lo_next[i] = ovf_main[i] ? hi_reg[i]
                                   : lo_reg[i] + 8'h1;
                    end
                end
                default: begin
                    if (i == 0 && go) begin
                        lo_next[i] = lo_reg[i] + 8'h1;
                        ovf_main[i] = (lo_reg[i] == 8'hff);
                    end
                    if (go_hi) begin
                        hi_next[i] = hi_reg[i] + 8'h1;
                    end
                end
            endcase
        end

        // count bytes: a bus write to a byte replaces its count
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                lo_reg[i] <= BYTE_RST;
                hi_reg[i] <= BYTE_RST;
            end else begin
                if (wr_en && wr_addr_reg == (i == 0 ? T0LO_ADDR
                                                    : T1LO_ADDR)) begin
                    lo_reg[i] <= HWDATA[7:0];
                end else begin
                    lo_reg[i] <= lo_next[i];
                end
                if (wr_en && wr_addr_reg == (i == 0 ? T0HI_ADDR
                                                    : T1HI_ADDR)) begin
                    hi_reg[i] <= HWDATA[7:0];
                end else begin
                    hi_reg[i] <= hi_next[i];
                end
            end
        end
    end

    // split high byte overflow feeds the timer1 flag
    assign ovf_hi0 = g_tmr[0].go_hi && (hi_reg[0] == 8'hff);

    // timer1 overflow pulse for baud and converter users
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf1_reg <= 1'b0;
        end else begin
            ovf1_reg <= ovf_main[1];
        end
    end
    assign TIMER1_OVF_PULSE = ovf1_reg;

    // interrupt requests
    assign TIMER0_IRQ = ctrl_reg[TF0_BIT] & ien_reg[ET0_BIT];
    assign TIMER1_IRQ = ctrl_reg[TF1_BIT] & ien_reg[ET1_BIT];
endmodule : dual_timer
`default_nettype wire

// [core/pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser plus one history stage for edge detection
module pin_sync (
    input wire logic CLK, // system clock
    input wire logic RST_N, // async reset, active low
    input wire logic PIN, // raw pin level
    output logic LEVEL, // synchronised level
    output logic FALL, // one-cycle pulse on high-to-low
    output logic RISE // one-cycle pulse on low-to-high
);
    logic meta_reg; // first stage, read only by sync_reg
    logic sync_reg; // second stage
    logic hist_reg; // previous synchronised level

    // resync chain; reset to the idle-high level so no false edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            hist_reg <= 1'b1;
        end else begin
            meta_reg <= PIN;
            sync_reg <= meta_reg;
            hist_reg <= sync_reg;
        end
    end

    assign LEVEL = sync_reg;
    assign FALL = hist_reg & ~sync_reg;
    assign RISE = ~hist_reg & sync_reg;
endmodule : pin_sync
`default_nettype wire

// [core/timer_pkg.sv]
package timer_pkg;
    // register byte addresses on the bus, one aligned word each
    localparam logic [7:0] CTRL_ADDR = 8'h00; // timer_control_reg
    localparam logic [7:0] MODE_ADDR = 8'h04; // timer_mode_reg
    localparam logic [7:0] CLKC_ADDR = 8'h08; // clock_control_reg
    localparam logic [7:0] T0LO_ADDR = 8'h0c; // timer0_low_byte
    localparam logic [7:0] T1LO_ADDR = 8'h10; // timer1_low_byte
    localparam logic [7:0] T0HI_ADDR = 8'h14; // timer0_high_byte
    localparam logic [7:0] T1HI_ADDR = 8'h18; // timer1_high_byte
    localparam logic [7:0] EXTC_ADDR = 8'h1c; // ext_input_config_reg
    localparam logic [7:0] IEN_ADDR = 8'h20; // interrupt_enable_reg

    // timer_control_reg fields
    localparam int TF1_BIT = 7;
    localparam int TR1_BIT = 6;
    localparam int TF0_BIT = 5;
    localparam int TR0_BIT = 4;
    // timer_mode_reg: per timer nibble {gate, count select, mode[1:0]}
    localparam int MODE_NIB = 4;
    localparam int GATE_OFS = 3;
    localparam int CSEL_OFS = 2;
    // clock_control_reg: sysclk select of timer0 at bit 3, timer1 at 2
    localparam int SYS0_BIT = 3;
    localparam int SCA_LSB = 0;
    // ext_input_config_reg: gate polarity bits
    localparam int POL0_BIT = 3;
    localparam int POL1_BIT = 7;
    // interrupt_enable_reg
    localparam int ET0_BIT = 1;
    localparam int ET1_BIT = 3;

    // values after reset
    localparam logic [7:0] BYTE_RST = 8'h00;

    // prescaler counts
    localparam logic [3:0] DIV12_LAST = 4'hb; // sysclk / 12
    localparam logic [1:0] DIV4_LAST = 2'h3; // sysclk / 4
    localparam logic [2:0] DIV8_LAST = 3'h7; // ext clock / 8

    // prescaler selections
    localparam logic [1:0] SCA_DIV12 = 2'h0;
    localparam logic [1:0] SCA_EXT8 = 2'h3;

    // synchronised input lanes
    localparam int LANE_CNT0 = 0;
    localparam int LANE_CNT1 = 1;
    localparam int LANE_TIMER0_GATE_ENABLE = 2;
    localparam int LANE_GATE1 = 3;
    localparam int LANE_EXTC = 4;
    localparam int LANES = 5;

    // operating modes
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } mode_t;
endpackage : timer_pkg

// [tb/dual_timer_props.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_timer_props
    import timer_pkg::*;
#(
    parameter int ADDR_W = 8 // decoded address width
) (
    input wire logic CLK, // system clock
    input wire logic RST_N, // async reset, active low
    input wire logic HSEL, // slave select
    input wire logic [ADDR_W-1:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write when high
    input wire logic [31:0] HWDATA, // write data
    input wire logic HREADY, // bus ready
    input wire logic [31:0] HRDATA, // read data
    input wire logic HREADYOUT, // ready out
    input wire logic HRESP, // response
    input wire logic TIMER0_IRQ, // timer0 request
    input wire logic TIMER1_IRQ // timer1 request
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic take; // address phase accepted
    logic wp_reg; // a write data phase is running
    logic [7:0] wa_reg; // address of that write
    logic [7:0] ctrl_sh, mode_sh, ien_sh; // software copies
    assign take = HSEL && HTRANS[1] && HREADY;
    // remember the write address for its data phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wp_reg <= 1'b0;
            wa_reg <= 8'h00;
        end else begin
            wp_reg <= take && HWRITE;
            wa_reg <= 8'(HADDR);
        end
    end
    // copies land on the same edge as the real registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_sh <= 8'h00;
            mode_sh <= 8'h00;
            ien_sh <= 8'h00;
        end else if (wp_reg) begin
            if (wa_reg == CTRL_ADDR) ctrl_sh <= HWDATA[7:0];
            if (wa_reg == MODE_ADDR) mode_sh <= HWDATA[7:0];
            if (wa_reg == IEN_ADDR) ien_sh <= HWDATA[7:0];
        end
    end
    sequence rd_of(logic [7:0] a);
        take && !HWRITE && HADDR == a;
    endsequence
    // software write of a one into a flag bit
    sequence flag_wr(int b);
        take && HWRITE && HADDR == CTRL_ADDR ##1 HWDATA[b];
    endsequence
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready or not okay");
    a_rdata_narrow: assert property (
        take && !HWRITE |=> HRDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (
        take && !HWRITE && HADDR > IEN_ADDR |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_mode_readback: assert property (
        rd_of(MODE_ADDR) |=> HRDATA[7:0] == $past(mode_sh))
        else $error("mode register read back wrong");
    a_run_readback: assert property (
        rd_of(CTRL_ADDR) |=> HRDATA[TR0_BIT] == $past(ctrl_sh[TR0_BIT])
        && HRDATA[TR1_BIT] == $past(ctrl_sh[TR1_BIT]) && HRDATA[3:0] == 4'h0)
        else $error("run bits read back wrong");
    a_irq0_masked: assert property (TIMER0_IRQ |-> ien_sh[ET0_BIT])
        else $error("timer0 request while disabled");
    a_irq1_masked: assert property (TIMER1_IRQ |-> ien_sh[ET1_BIT])
        else $error("timer1 request while disabled");
    a_flag0_request: assert property (
        flag_wr(TF0_BIT) |=> TIMER0_IRQ == ien_sh[ET0_BIT])
        else $error("timer0 flag not forwarded");
    a_flag1_request: assert property (
        flag_wr(TF1_BIT) |=> TIMER1_IRQ == ien_sh[ET1_BIT])
        else $error("timer1 flag not forwarded");
endmodule : dual_timer_props
bind dual_timer dual_timer_props #(.ADDR_W(ADDR_W)) i_props (.CLK(CLK),
    .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER0_IRQ(TIMER0_IRQ),
    .TIMER1_IRQ(TIMER1_IRQ));
`default_nettype wire

// [tb/test_dual_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_dual_timer
    import timer_pkg::*;
;
    logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0; // bus side
    logic [7:0] HADDR = 8'h00; // byte address
    logic [1:0] HTRANS = 2'h0; // idle at start
    logic [2:0] HSIZE = 3'h2; // word
    logic [31:0] HWDATA = 32'h0, HRDATA, rd; // data and last read
    logic HREADYOUT, HRESP, IRQ0, IRQ1, OVF1; // design outputs
    logic P0, P1, G0, G1, XCLK; // pin side
    int n_mismatch = 0, total_checks = 0, n_ovf = 0; // tallies
    logic [7:0] sel[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08}; // clock picks
    int lo[5] = '{19, 59, 59, 3, 238}; // least count in the run window
    int hi[5] = '{22, 62, 62, 6, 246}; // most count in the run window
    always #5 CLK = !CLK;
    // overflow pulses of timer1 seen by other users
    always @(posedge CLK) if (OVF1 === 1'b1) n_ovf <= n_ovf + 1;
    dual_timer i_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .TIMER0_COUNT_PIN(P0), .TIMER1_COUNT_PIN(P1),
        .GATE_INPUT0(G0), .GATE_INPUT1(G1), .EXT_CLK(XCLK),
        .TIMER0_IRQ(IRQ0), .TIMER1_IRQ(IRQ1), .TIMER1_OVF_PULSE(OVF1));
    timer_pin_model i_pins (.clk(CLK), .cnt0(P0), .cnt1(P1), .timer0_gate_enable(G0),
        .gate1(G1), .ext_clk(XCLK));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, d};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rdc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // cut a hang short, well past the expected run length
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        // all registers clear, 0x24 unmapped
        for (int i = 0; i <= 9; i++) rdc(8'(i * 4), 8'h00);
        wr(T0LO_ADDR, 8'h5a);
        wr(T0HI_ADDR, 8'ha5);
        rdc(T0LO_ADDR, 8'h5a);
        rdc(T0HI_ADDR, 8'ha5);
        // flags set by software reach the request lines only when enabled
        wr(IEN_ADDR, 8'h0a);
        wr(CTRL_ADDR, 8'ha0);
        @(posedge CLK);
        chk(32'({IRQ1, IRQ0}), 32'h3);
        wr(IEN_ADDR, 8'h02);
        @(posedge CLK);
        chk(32'({IRQ1, IRQ0}), 32'h1);
        // 13-bit count of pin edges across the wrap
        wr(MODE_ADDR, 8'h04);
        wr(T0HI_ADDR, 8'hff);
        wr(T0LO_ADDR, 8'h1e);
        wr(CTRL_ADDR, 8'h10);
        rdc(T0LO_ADDR, 8'h1e);
        i_pins.pulse(0, 3);
        rdc(T0LO_ADDR, 8'h01);
        rdc(T0HI_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h30);
        @(posedge CLK);
        chk(32'(IRQ0), 32'h1);
        // gate closed, then open at each polarity
        wr(MODE_ADDR, 8'h0c);
        wr(EXTC_ADDR, 8'h08);
        i_pins.pulse(0, 2);
        rdc(T0LO_ADDR, 8'h01);
        i_pins.gate(0, 1'b1);
        i_pins.pulse(0, 2);
        rdc(T0LO_ADDR, 8'h03);
        wr(EXTC_ADDR, 8'h00);
        i_pins.gate(0, 1'b0);
        i_pins.pulse(0, 1);
        rdc(T0LO_ADDR, 8'h04);
        // timer1 auto-reload from its pin
        wr(MODE_ADDR, 8'h60);
        wr(T1HI_ADDR, 8'h80);
        wr(T1LO_ADDR, 8'hfe);
        wr(CTRL_ADDR, 8'h40);
        i_pins.pulse(1, 3);
        rdc(T1LO_ADDR, 8'h81);
        rdc(T1HI_ADDR, 8'h80);
        rdc(CTRL_ADDR, 8'hc0);
        // timer1 gated by its own line at its own polarity
        wr(EXTC_ADDR, 8'h80);
        wr(MODE_ADDR, 8'he0);
        i_pins.pulse(1, 1);
        rdc(T1LO_ADDR, 8'h81);
        i_pins.gate(1, 1'b1);
        i_pins.pulse(1, 1);
        rdc(T1LO_ADDR, 8'h82);
        // split: high byte on the timer1 run bit, timer1 halted
        wr(CTRL_ADDR, 8'h00);
        wr(CLKC_ADDR, 8'h08);
        wr(T0HI_ADDR, 8'hf8);
        wr(T0LO_ADDR, 8'h10);
        wr(T1LO_ADDR, 8'h33);
        wr(MODE_ADDR, 8'h33);
        wr(CTRL_ADDR, 8'h40);
        i_pins.pulse(1, 2);
        rdc(T0LO_ADDR, 8'h10);
        rdc(T1LO_ADDR, 8'h33);
        rdc(CTRL_ADDR, 8'hc0);
        // split: timer1 runs by mode alone, wraps without its flag
        wr(CTRL_ADDR, 8'h00);
        wr(T1HI_ADDR, 8'hff);
        wr(T1LO_ADDR, 8'hf0);
        wr(CLKC_ADDR, 8'h0c);
        n_ovf = 0;
        // pin select set on timer1, yet it must keep its internal clock
        wr(MODE_ADDR, 8'h53);
        repeat (40) @(posedge CLK);
        rdc(CTRL_ADDR, 8'h00);
        chk(32'(n_ovf > 0), 32'h1);
        // each clock choice over a fixed window
        wr(MODE_ADDR, 8'h01);
        for (int s = 0; s < 5; s++) begin
            wr(CLKC_ADDR, sel[s]);
            wr(T0LO_ADDR, 8'h00);
            wr(CTRL_ADDR, 8'h10);
            repeat (240) @(posedge CLK);
            wr(CTRL_ADDR, 8'h00);
            bus(1'b0, T0LO_ADDR, 8'h00);
            chk(32'(rd >= lo[s] && rd <= hi[s]), 32'h1);
        end
        end_of_test();
    end
endmodule : test_dual_timer
`default_nettype wire

// [tb/timer_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// count sources, gate lines and oscillator around the timers
module timer_pin_model (
    input wire logic clk, // system clock
    output logic cnt0, // timer0 count pin
    output logic cnt1, // timer1 count pin
    output logic timer0_gate_enable, // timer0 gate line
    output logic gate1, // timer1 gate line
    output logic ext_clk // free running oscillator
);
    initial begin
        cnt0 = 1'b1;
        cnt1 = 1'b1;
        timer0_gate_enable = 1'b0;
        gate1 = 1'b0;
        ext_clk = 1'b0;
    end
    // odd half period keeps its phase apart from the system clock
    always #31 ext_clk = !ext_clk;
    // n falling edges; each level kept three clocks, above the minimum
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            if (which == 0) cnt0 <= 1'b0; else cnt1 <= 1'b0;
            repeat (3) @(posedge clk);
            if (which == 0) cnt0 <= 1'b1; else cnt1 <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask : pulse
    // new gate level, given time to pass the synchroniser
    task automatic gate(input int which, input logic lvl);
        if (which == 0) timer0_gate_enable <= lvl; else gate1 <= lvl;
        repeat (3) @(posedge clk);
    endtask : gate
endmodule : timer_pin_model
`default_nettype wire
